// ---- qeltr_top.sv ----
// Quadrature encoder position counter and line trigger with Wishbone registers
// Summary of operation
// R1 - 24-bit up/down position counter from zero
// R2 - Counter readable anytime without disturbing it
// R3 - Direction derived from quarter-cycle phase relation
// R4 - Both phase edges serve as trigger sources
// R5 - Decode one: all edges of both phases
// R6 - Simple mode: trigger every counted edge
// R7 - Optionally trigger on increments or decrements only
// R8 - Window mode: trigger only between limits
// R9 - Window gating combines with direction selection
// R10 - No-repeat mode: each position triggers once
// R11 - Frame trigger every N counts when enabled
// R12 - All modes may be enabled together
// R13 - Status readable: count, phases, direction, window, activity
// R14 - Decode zero: rising edges of A and B
// R15 - Direction codes: both, positive, negative, reserved
// R16 - Phase-type selects single or two-phase encoder
// R17 - Write-only reset bit clears count, tracking, scan count, activity and triggers; motion direction is kept
// R18 - Inclusive limits; phases synchronised before decoding
// R19 - No-repeat tracks furthest value in enabled direction
`default_nettype none

module qeltr_top #(
	parameter int unsigned STEP_W = 24
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        reset,
	// Wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	// Encoder and trigger sources
	input  wire logic        phase_a,
	input  wire logic        phase_b,
	input  wire logic        ext_frame_trigger,
	// Triggers
	output logic             line_trigger,
	output logic             frame_trigger
);

	localparam int unsigned CW = qeltr_pkg::CNT_W;

	// Refuse step counter widths that the scan counter and register cannot hold
	if (STEP_W < 1 || STEP_W > qeltr_pkg::CNT_W) begin : g_step_w_check
		$error("STEP_W must lie between 1 and 24");
	end

	// ****************************************
	// Decoder
	// ****************************************
	qeltr_pkg::qeltr_ctrl_s ctrl_q, ctrl_d;
	logic                   step, up, a_lvl, b_lvl;

	qeltr_decode u_decode (
		.clk                (clk),
		.reset              (reset),
		.phase_a            (phase_a),
		.phase_b            (phase_b),
		.two_phase_select   (ctrl_q.two_phase_select),
		.edge_decode_select (ctrl_q.edge_decode_select),
		.step               (step),
		.up                 (up),
		.phase_a_level      (a_lvl),
		.phase_b_level      (b_lvl)
	);

	// ****************************************
	// Register bus
	// ****************************************
	logic [CW-1:0]     upper_q, upper_d;
	logic [STEP_W-1:0] step_n_q, step_n_d;
	logic              ack_q, ack_d;
	logic [31:0]       rdat_q, rdat_d;
	logic              enc_rst_q, enc_rst_d;
	logic [31:0]       wmask, ctrl_w, upper_w, step_w;
	logic              req, wr;
	logic [CW-1:0]     cnt_q;
	qeltr_pkg::qeltr_status_s status;

	always_comb begin
		req   = wb_cyc_i & wb_stb_i & ~ack_q;
		wr    = req & wb_we_i;
		wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
		ctrl_w  = ({1'b0, ctrl_q} & ~wmask) | (wb_dat_i & wmask);
		upper_w = ({{(32-CW){1'b0}}, upper_q} & ~wmask) | (wb_dat_i & wmask);
		step_w  = ({{(32-STEP_W){1'b0}}, step_n_q} & ~wmask) | (wb_dat_i & wmask);
		ack_d     = req;
		ctrl_d    = ctrl_q;
		upper_d   = upper_q;
		step_n_d  = step_n_q;
		enc_rst_d = 1'b0;
		rdat_d    = rdat_q;
		if (wr) begin
			unique case (wb_adr_i)
				qeltr_pkg::ADR_CTRL: begin
					ctrl_d    = ctrl_w[30:0];
					enc_rst_d = ctrl_w[qeltr_pkg::CTL_RESET]; // see R17
				end
				qeltr_pkg::ADR_UPPER: upper_d = upper_w[CW-1:0];
				qeltr_pkg::ADR_STEP: step_n_d = step_w[STEP_W-1:0];
				default: ;
			endcase
		end
		if (req) begin
			unique case (wb_adr_i)
				qeltr_pkg::ADR_CTRL: rdat_d = {1'b0, ctrl_q};
				qeltr_pkg::ADR_UPPER: rdat_d = {{(32-CW){1'b0}}, upper_q};
				qeltr_pkg::ADR_STEP: rdat_d = {{(32-STEP_W){1'b0}}, step_n_q};
				qeltr_pkg::ADR_COUNT: rdat_d = {{(32-CW){1'b0}}, cnt_q}; // see R2
				qeltr_pkg::ADR_STATUS: rdat_d = {27'h0, status}; // see R13
				default: rdat_d = 32'h0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			ctrl_q    <= qeltr_pkg::CTRL_RESET;
			upper_q   <= '0;
			step_n_q  <= qeltr_pkg::STEP_RESET[STEP_W-1:0];
			ack_q     <= 1'b0;
			rdat_q    <= 32'h0;
			enc_rst_q <= 1'b0;
		end else begin
			ctrl_q    <= ctrl_d;
			upper_q   <= upper_d;
			step_n_q  <= step_n_d;
			ack_q     <= ack_d;
			rdat_q    <= rdat_d;
			enc_rst_q <= enc_rst_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ****************************************
	// Counter and qualification
	// ****************************************
	logic [CW-1:0]     cnt_d, cnt_nx, ext_q, ext_d;
	logic              ext_ok_q, ext_ok_d, dir_q, dir_d, act_q, act_d;
	logic              line_q, line_d, frame_q, frame_d;
	logic [STEP_W-1:0] sc_q, sc_d;
	logic              dir_ok, win_ok, rep_ok, qual, track_up, scan_hit;

	always_comb begin
		cnt_nx = up ? cnt_q + 1'b1 : cnt_q - 1'b1; // see R1
		unique case (ctrl_q.acquire_direction_select) // see R15
			qeltr_pkg::DIR_POS: dir_ok = up; // see R7
			qeltr_pkg::DIR_NEG: dir_ok = ~up;
			default: dir_ok = 1'b1;
		endcase
		win_ok   = ~ctrl_q.window_gate_enable | // see R8 // see R9 // see R18
			(cnt_nx >= ctrl_q.window_lower_limit && cnt_nx <= upper_q);
		track_up = ctrl_q.acquire_direction_select != qeltr_pkg::DIR_NEG;
		rep_ok   = ~ctrl_q.repeat_line_block_enable | ~ext_ok_q | // see R10 // see R19
			(track_up ? cnt_nx > ext_q : cnt_nx < ext_q);
		qual     = step & dir_ok & win_ok & rep_ok; // see R6 // see R12
		scan_hit = {1'b0, sc_q} + 1'b1 >= {1'b0, step_n_q};
		cnt_d    = cnt_q;
		dir_d    = dir_q;
		ext_d    = ext_q;
		ext_ok_d = ext_ok_q;
		act_d    = act_q;
		sc_d     = sc_q;
		line_d   = qual;
		frame_d  = ctrl_q.frame_step_trigger_enable ? 1'b0 : ext_frame_trigger;
		if (step) begin
			cnt_d = cnt_nx;
			dir_d = up;
			act_d = qual;
		end
		if (qual) begin
			ext_d    = cnt_nx;
			ext_ok_d = 1'b1;
			if (ctrl_q.frame_step_trigger_enable) begin
				sc_d    = scan_hit ? '0 : sc_q + 1'b1; // see R11
				frame_d = scan_hit;
			end
		end
		if (enc_rst_q) begin
			cnt_d    = '0; // see R17
			ext_d    = '0;
			ext_ok_d = 1'b0;
			act_d    = 1'b0;
			sc_d     = '0;
			line_d   = 1'b0;
			frame_d  = 1'b0;
		end
		status.phase_a_level            = a_lvl;
		status.phase_b_level            = b_lvl;
		status.motion_direction_status  = dir_q;
		status.inside_window_status     = cnt_q >= ctrl_q.window_lower_limit && cnt_q <= upper_q;
		status.new_line_activity_status = act_q;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_q    <= '0;
			dir_q    <= 1'b0;
			ext_q    <= '0;
			ext_ok_q <= 1'b0;
			act_q    <= 1'b0;
			sc_q     <= '0;
			line_q   <= 1'b0;
			frame_q  <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			dir_q    <= dir_d;
			ext_q    <= ext_d;
			ext_ok_q <= ext_ok_d;
			act_q    <= act_d;
			sc_q     <= sc_d;
			line_q   <= line_d;
			frame_q  <= frame_d;
		end
	end

	assign line_trigger  = line_q;
	assign frame_trigger = frame_q;

	// ****************************************
	// Assertions
	// ****************************************
	sequence s_rst_write;
		wr && wb_adr_i == qeltr_pkg::ADR_CTRL && wb_sel_i[3] && wb_dat_i[qeltr_pkg::CTL_RESET];
	endsequence

	sequence s_step_up;
		step && up && !enc_rst_q;
	endsequence

	property p_count_up;
		@(posedge clk) disable iff (reset) s_step_up |=> cnt_q == $past(cnt_q) + 1'b1;
	endproperty
	a_count_up: assert property (p_count_up) else $error("counter missed an up step"); // see R1

	property p_count_dir;
		@(posedge clk) disable iff (reset) step && !up && !enc_rst_q |=> cnt_q == $past(cnt_q) - 1'b1 && !dir_q;
	endproperty
	a_count_dir: assert property (p_count_dir) else $error("down step not counted down"); // see R3

	property p_count_read;
		@(posedge clk) disable iff (reset)
			req && !wb_we_i && wb_adr_i == qeltr_pkg::ADR_COUNT |=> wb_ack_o && wb_dat_o[CW-1:0] == $past(cnt_q);
	endproperty
	a_count_read: assert property (p_count_read) else $error("count read wrong"); // see R2

	property p_simple;
		@(posedge clk) disable iff (reset)
			step && !enc_rst_q && ctrl_q[29:25] == 5'h10 |=> line_trigger;
	endproperty
	a_simple: assert property (p_simple) else $error("simple mode edge gave no line"); // see R6

	property p_pos_only;
		@(posedge clk) disable iff (reset)
			line_trigger && $past(ctrl_q.acquire_direction_select) == qeltr_pkg::DIR_POS |-> $past(up);
	endproperty
	a_pos_only: assert property (p_pos_only) else $error("line on decrement in positive mode"); // see R7

	property p_window;
		@(posedge clk) disable iff (reset)
			line_trigger && $past(ctrl_q.window_gate_enable) |->
			$past(cnt_d) >= $past(ctrl_q.window_lower_limit) && $past(cnt_d) <= $past(upper_q);
	endproperty
	a_window: assert property (p_window) else $error("line outside window"); // see R8

	property p_no_repeat;
		@(posedge clk) disable iff (reset)
			line_trigger && $past(ctrl_q.repeat_line_block_enable) && $past(ext_ok_q) && $past(track_up)
			|-> $past(cnt_d) > $past(ext_q);
	endproperty
	a_no_repeat: assert property (p_no_repeat) else $error("position triggered twice"); // see R10

	property p_scan;
		@(posedge clk) disable iff (reset)
			frame_trigger && $past(ctrl_q.frame_step_trigger_enable) |-> $past(qual) && $past(scan_hit);
	endproperty
	a_scan: assert property (p_scan) else $error("frame trigger off the step count"); // see R11

	property p_enc_reset;
		@(posedge clk) disable iff (reset) s_rst_write |=> enc_rst_q ##1 cnt_q == '0 && !ext_ok_q && sc_q == '0;
	endproperty
	a_enc_reset: assert property (p_enc_reset) else $error("encoder reset did not clear"); // see R17

endmodule // qeltr_top

`default_nettype wire

// ---- qeltr_pkg.sv ----
// Package with register map, field layout and status layout of the encoder line trigger
`default_nettype none

package qeltr_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int unsigned ADR_W      = 8;
	localparam logic [7:0]  ADR_CTRL   = 8'h00;
	localparam logic [7:0]  ADR_UPPER  = 8'h04;
	localparam logic [7:0]  ADR_STEP   = 8'h08;
	localparam logic [7:0]  ADR_COUNT  = 8'h0c;
	localparam logic [7:0]  ADR_STATUS = 8'h10;

	// ****************************************
	// Control word fields
	// ****************************************
	localparam int unsigned CNT_W      = 24;
	localparam int unsigned CTL_RESET  = 31;
	localparam logic [1:0]  DIR_BOTH   = 2'h0;
	localparam logic [1:0]  DIR_POS    = 2'h1;
	localparam logic [1:0]  DIR_NEG    = 2'h2;
	localparam logic [23:0] STEP_RESET = 24'h000001;

	typedef struct packed {
		logic              frame_step_trigger_enable;
		logic              two_phase_select;
		logic              repeat_line_block_enable;
		logic              window_gate_enable;
		logic [1:0]        acquire_direction_select;
		logic              edge_decode_select;
		logic [CNT_W-1:0]  window_lower_limit;
	} qeltr_ctrl_s;

	localparam qeltr_ctrl_s CTRL_RESET = '0;

	// ****************************************
	// Status word layout
	// ****************************************
	typedef struct packed {
		logic new_line_activity_status;
		logic inside_window_status;
		logic motion_direction_status;
		logic phase_b_level;
		logic phase_a_level;
	} qeltr_status_s;

endpackage : qeltr_pkg

`default_nettype wire

// ---- qeltr_decode.sv ----
// Phase input synchroniser and quadrature edge decoder
`default_nettype none

module qeltr_decode (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// Encoder phases
	input  wire logic phase_a,
	input  wire logic phase_b,
	// Mode
	input  wire logic two_phase_select,
	input  wire logic edge_decode_select,
	// Decoded movement
	output logic      step,
	output logic      up,
	output logic      phase_a_level,
	output logic      phase_b_level
);

	logic [2:0] a_q, a_d;
	logic [2:0] b_q, b_d;
	logic       a_rise, a_fall, b_rise, b_fall;

	// ****************************************
	// Synchroniser plus one edge stage
	// ****************************************
	always_comb begin
		a_d = {a_q[1:0], phase_a};
		b_d = {b_q[1:0], phase_b};
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			a_q <= 3'h0;
			b_q <= 3'h0;
		end else begin
			a_q <= a_d;
			b_q <= b_d;
		end
	end

	// ****************************************
	// Edge and direction decode
	// ****************************************
	always_comb begin
		a_rise        = a_q[1] & ~a_q[2];
		a_fall        = ~a_q[1] & a_q[2];
		b_rise        = b_q[1] & ~b_q[2];
		b_fall        = ~b_q[1] & b_q[2];
		phase_a_level = a_q[2];
		phase_b_level = b_q[2];
		if (two_phase_select) begin
			step = a_rise | b_rise | (edge_decode_select & (a_fall | b_fall)); // see R4 // see R5 // see R14
			if (a_rise)
				up = ~b_q[1]; // see R3
			else if (b_rise)
				up = a_q[1];
			else if (a_fall)
				up = b_q[1];
			else
				up = ~a_q[1];
		end else begin
			step = a_rise | (edge_decode_select & a_fall); // see R16
			up   = 1'b1;
		end
	end

endmodule // qeltr_decode

`default_nettype wire

// ---- qeltr_enc_model.sv ----
// Behavioural quadrature encoder that drives the two phase inputs
`default_nettype none

module qeltr_enc_model (
	// Clock
	input  wire logic clk,
	// Encoder phases
	output var logic  phase_a,
	output var logic  phase_b
);
	timeunit 1ns;
	timeprecision 1ps;

	int pos = 0;

	initial begin
		phase_a = 1'b0;
		phase_b = 1'b0;
	end

	// Gray sequence with A leading B when moving up, six clocks per quarter
	task automatic move(input int n);
		for (int i = 0; i < (n < 0 ? -n : n); i++) begin
			@(posedge clk);
			pos = pos + (n < 0 ? -1 : 1);
			phase_a <= (pos & 3) inside {1, 2};
			phase_b <= (pos & 3) inside {2, 3};
			repeat (5) @(posedge clk);
		end
	endtask
endmodule // qeltr_enc_model

`default_nettype wire

// ---- qeltr_top_tb.sv ----
// Self-checking bench for the encoder line trigger
`default_nettype none

module qeltr_top_tb;
	timeunit 1ns;
	timeprecision 1ps;

	localparam logic [31:0] TWO = 32'h2000_0000, D4 = 32'h0100_0000, WIN = 32'h0800_0000;
	localparam logic [31:0] NOREP = 32'h1000_0000, STEPM = 32'h4000_0000, ERST = 32'h8000_0000;
	localparam logic [31:0] POS = 32'h0200_0000;

	logic        clk = 1'b0, reset = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, ext = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wdat = 32'h0, dat_o, lines = 32'h0, frames = 32'h0, l0, f0;
	logic        ack, pa, pb, line_trg, frame_trg;
	int          miscompares = 0, samples_checked = 0;

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		lines <= lines + 32'(line_trg);
		frames <= frames + 32'(frame_trg);
	end

	qeltr_top qeltr_top_i (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .phase_a(pa), .phase_b(pb),
		.ext_frame_trigger(ext), .line_trigger(line_trg), .frame_trigger(frame_trg));
	qeltr_enc_model qeltr_enc_model_i (.clk(clk), .phase_a(pa), .phase_b(pb));

	// ****************************************
	// Bus cycles and comparisons
	// ****************************************
	task automatic end_sim();
		if (miscompares == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		repeat (20) begin
			@(posedge clk);
			if (ack === 1'b1)
				break;
		end
		if (ack !== 1'b1) begin
			miscompares++;
			end_sim();
		end
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, a, 32'h0, q);
		chk(what, exp, q);
	endtask

	// Encoder reset with new mode, then snapshot of the trigger counts
	task automatic setup(input logic [31:0] cfg);
		wr(qeltr_pkg::ADR_CTRL, cfg | ERST);
		l0 = lines;
		f0 = frames;
	endtask

	task automatic result(input string what, input logic [31:0] cnt, input logic [31:0] nl);
		rd_chk(what, qeltr_pkg::ADR_COUNT, cnt);
		chk(what, nl, lines - l0);
	endtask

	task automatic mv(input int n);
		qeltr_enc_model_i.move(n);
	endtask

	initial begin
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd_chk("ctrl", qeltr_pkg::ADR_CTRL, 32'h0);
		rd_chk("upper", qeltr_pkg::ADR_UPPER, 32'h0);
		rd_chk("step", qeltr_pkg::ADR_STEP, 32'h1);
		rd_chk("count", qeltr_pkg::ADR_COUNT, 32'h0);
		rd_chk("unmapped", 8'h14, 32'h0);
		setup(32'h0);
		mv(4);
		mv(-4);
		result("single", 32'h2, 32'h2);
		setup(TWO);
		mv(1);
		rd_chk("status up", qeltr_pkg::ADR_STATUS, 32'h15);
		mv(3);
		mv(-4);
		result("x2", 32'h0, 32'h4);
		rd_chk("status down", qeltr_pkg::ADR_STATUS, 32'h18);
		for (int c = 0; c < 4; c++) begin
			setup(TWO | D4 | (32'(c) << 25));
			mv(4);
			mv(-4);
			result("direction", 32'h0, (c == 0 || c == 3) ? 32'h8 : 32'h4);
		end
		setup(TWO | D4);
		mv(-1);
		result("wrap", 32'h00ff_ffff, 32'h1);
		wr(qeltr_pkg::ADR_UPPER, 32'h3);
		setup(TWO | D4 | WIN | 32'h2);
		mv(6);
		rd_chk("outside", qeltr_pkg::ADR_STATUS, 32'h05);
		mv(-3);
		rd_chk("inside", qeltr_pkg::ADR_STATUS, 32'h1b);
		result("window", 32'h3, 32'h3);
		setup(TWO | D4 | NOREP | POS);
		mv(4);
		mv(-2);
		mv(3);
		result("no repeat", 32'h5, 32'h5);
		ext <= 1'b1;
		@(posedge clk);
		ext <= 1'b0;
		repeat (3) @(posedge clk);
		chk("ext frame", 32'h1, frames - f0);
		wr(qeltr_pkg::ADR_STEP, 32'h3);
		setup(TWO | D4 | STEPM);
		mv(6);
		result("step lines", 32'h6, 32'h6);
		chk("step frames", 32'h2, frames - f0);
		rd_chk("ctrl keep", qeltr_pkg::ADR_CTRL, TWO | D4 | STEPM);
		wr(qeltr_pkg::ADR_CTRL, ERST | TWO);
		rd_chk("count clear", qeltr_pkg::ADR_COUNT, 32'h0);
		end_sim();
	end
endmodule // qeltr_top_tb

`default_nettype wire
